// ---- tmc_regs.svh ----
// Constants for the thermal monitor control block
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
`define TMC_CLK_MHZ 25
`define TMC_DEBOUNCE_US 10
`define TMC_DEBOUNCE_CYC (`TMC_DEBOUNCE_US * `TMC_CLK_MHZ)
`define TMC_WINDOW_US 450
`define TMC_WINDOW_CYC (`TMC_WINDOW_US * `TMC_CLK_MHZ)
`define TMC_PERIOD_US 3000
`define TMC_PERIOD_CYC (`TMC_PERIOD_US * `TMC_CLK_MHZ)
`define TMC_NUM_THRESH 6
`define TMC_THRESH_HYS_C 5
`define TMC_SD_HYS_C 15
`define TMC_SD_TRIP_C 165
`endif

// ---- tmc_pkg.sv ----
// Types for the thermal monitor control block
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_OFF = 2'b00,
    TMC_SAMPLE_ON = 2'b01,
    TMC_SAMPLE_IDLE = 2'b11,
    TMC_ALWAYS_ON = 2'b10
  } tmc_mode_t;
endpackage

// ---- tmc_thermal_monitor_control.sv ----
// Thermal monitor control: sampling, debounce, flags and shutdown latch
// Operation
// - Debounce threshold and trip comparators 10 us both directions; release comparator not debounced
// - Sampling: 450 us window every 3.0 ms
// - Run with always-on set: continuous sensing
// - Run with always-on clear: sampling mode
// - Enable clear stops sensing and drops threshold senses; shutdown latch still acts on held trip and release
// - Standby: sampling only, while enabled
// - Accepted crossing sets threshold interrupt flag
// - Six thresholds, each flag, sense, mask
// - Sense released 5 C below threshold
// - Shutdown latched until 15 C hysteresis cleared
// - Shutdown trips at 165 C
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_thermal_monitor_control import tmc_pkg::*; #(
  parameter int NUM_THRESH = `TMC_NUM_THRESH,
  parameter int DEBOUNCE_CYC = `TMC_DEBOUNCE_CYC,
  parameter int WINDOW_CYC = `TMC_WINDOW_CYC,
  parameter int PERIOD_CYC = `TMC_PERIOD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic temp_monitor_enable_i,
  input wire logic monitor_always_on_i,
  input wire logic run_state_i,
  input wire logic standby_state_i,
  input wire logic [NUM_THRESH-1:0] thresh_comp_i,
  input wire logic shutdown_trip_level_i,
  input wire logic shutdown_release_i,
  input wire logic [NUM_THRESH-1:0] irq_flag_clear_i,
  input wire logic [NUM_THRESH-1:0] thermal_thresh_mask_i,
  output logic sensor_power_o,
  output logic [NUM_THRESH-1:0] thermal_thresh_irq_flag_o,
  output logic [NUM_THRESH-1:0] thermal_thresh_sense_o,
  output logic thermal_irq_o,
  output logic thermal_shutdown_o
);

  localparam int CW = $clog2(PERIOD_CYC + 1);
  localparam int DW = $clog2(DEBOUNCE_CYC + 1);
  localparam int NC = NUM_THRESH + 2;
  localparam int TRIP_BIT = NUM_THRESH;
  localparam int RELEASE_BIT = NUM_THRESH + 1;
  localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] WINDOW_END = CW'(WINDOW_CYC);
  localparam logic [DW-1:0] DEBOUNCE_LAST = DW'(DEBOUNCE_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NC-1:0] sync1;
    logic [NC-1:0] sync2;
    tmc_mode_t mode;
    logic [CW-1:0] period_cnt;
    logic [NUM_THRESH:0][DW-1:0] db_cnt;
    logic [NUM_THRESH:0] stable;
    logic [NUM_THRESH-1:0] flag;
    logic shutdown;
    logic irq;
  } tmc_state_t;

  tmc_state_t st;
  tmc_state_t next_st;
  logic sensing;
  logic [NUM_THRESH:0] raw;
  logic [NUM_THRESH-1:0] crossed;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Enabled and in Run or Standby
  function automatic logic monitor_allowed(
    input logic enable,
    input logic run,
    input logic standby
  );
    logic allowed;
    allowed = enable && (run || standby);
    return allowed;
  endfunction

  // Continuous sensing only in Run
  function automatic logic continuous_wanted(
    input logic run,
    input logic always_on
  );
    logic wanted;
    wanted = run && always_on;
    return wanted;
  endfunction

  // Sensing circuit powered in this mode
  function automatic logic is_sensing(
    input tmc_mode_t mode
  );
    logic result;
    unique case (mode)
      TMC_OFF: begin
        result = 1'b0;
      end
      TMC_SAMPLE_ON: begin
        result = 1'b1;
      end
      TMC_SAMPLE_IDLE: begin
        result = 1'b0;
      end
      TMC_ALWAYS_ON: begin
        result = 1'b1;
      end
    endcase
    return result;
  endfunction

  // Duty cycle counter, restarts on entry to sampling
  function automatic logic [CW-1:0] period_step(
    input tmc_mode_t mode,
    input logic [CW-1:0] cnt
  );
    logic [CW-1:0] step;
    if (mode == TMC_OFF || mode == TMC_ALWAYS_ON) begin
      step = '0;
    end else if (cnt == PERIOD_LAST) begin
      step = '0;
    end else begin
      step = cnt + 1'b1;
    end
    return step;
  endfunction

  // Powered part of the sampling period
  function automatic tmc_mode_t window_mode(
    input logic [CW-1:0] cnt
  );
    tmc_mode_t mode;
    if (cnt < WINDOW_END) begin
      mode = TMC_SAMPLE_ON;
    end else begin
      mode = TMC_SAMPLE_IDLE;
    end
    return mode;
  endfunction

  // Debounce counter, cleared on agreement or power loss
  function automatic logic [DW-1:0] debounce_count(
    input logic powered,
    input logic sample,
    input logic held,
    input logic [DW-1:0] cnt
  );
    logic [DW-1:0] count;
    if (!powered || sample == held) begin
      count = '0;
    end else if (cnt == DEBOUNCE_LAST) begin
      count = '0;
    end else begin
      count = cnt + 1'b1;
    end
    return count;
  endfunction

  // New level accepted after full debounce time
  function automatic logic debounce_accept(
    input logic powered,
    input logic sample,
    input logic held,
    input logic [DW-1:0] cnt
  );
    logic accept;
    accept = powered && (sample != held) && (cnt == DEBOUNCE_LAST);
    return accept;
  endfunction

  // Low to high change
  function automatic logic rising(
    input logic now_level,
    input logic old_level
  );
    logic edge_seen;
    edge_seen = now_level && !old_level;
    return edge_seen;
  endfunction

  // Sticky bit, set wins over clear
  function automatic logic sticky_flag(
    input logic set_req,
    input logic clr_req,
    input logic flag
  );
    logic result;
    if (set_req) begin
      result = 1'b1;
    end else if (clr_req) begin
      result = 1'b0;
    end else begin
      result = flag;
    end
    return result;
  endfunction

  // Any unmasked flag
  function automatic logic irq_request(
    input logic [NUM_THRESH-1:0] flags,
    input logic [NUM_THRESH-1:0] mask
  );
    logic request;
    request = |(flags & ~mask);
    return request;
  endfunction

  // Sense dropped while monitoring is off
  function automatic logic [NUM_THRESH-1:0] clear_when_off(
    input tmc_mode_t mode,
    input logic [NUM_THRESH-1:0] sense
  );
    logic [NUM_THRESH-1:0] kept;
    if (mode == TMC_OFF) begin
      kept = '0;
    end else begin
      kept = sense;
    end
    return kept;
  endfunction

  // Threshold part of the debounced levels
  function automatic logic [NUM_THRESH-1:0] sense_view(
    input logic [NUM_THRESH:0] held
  );
    logic [NUM_THRESH-1:0] view;
    view = held[NUM_THRESH-1:0];
    return view;
  endfunction

  // Comparator pins in synchroniser order
  function automatic logic [NC-1:0] pin_vector(
    input logic release_pin,
    input logic trip_pin,
    input logic [NUM_THRESH-1:0] comp_pins
  );
    logic [NC-1:0] pins;
    pins = {release_pin, trip_pin, comp_pins};
    return pins;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    raw = st.sync2[TRIP_BIT:0];
    crossed = '0;
    // Pins pass two flops before use
    next_st.sync1 = pin_vector(shutdown_release_i, shutdown_trip_level_i, thresh_comp_i);
    next_st.sync2 = st.sync1;
    // Mode selection
    if (!monitor_allowed(temp_monitor_enable_i, run_state_i, standby_state_i)) begin
      next_st.mode = TMC_OFF;
      next_st.period_cnt = '0;
    end else if (continuous_wanted(run_state_i, monitor_always_on_i)) begin
      next_st.mode = TMC_ALWAYS_ON;
      next_st.period_cnt = '0;
    end else begin
      next_st.period_cnt = period_step(st.mode, st.period_cnt);
      next_st.mode = window_mode(next_st.period_cnt);
    end
    // Debounce, only while sensing is powered
    for (int i = 0; i <= NUM_THRESH; i++) begin
      next_st.db_cnt[i] = debounce_count(sensing, raw[i], st.stable[i], st.db_cnt[i]);
      if (debounce_accept(sensing, raw[i], st.stable[i], st.db_cnt[i])) begin
        next_st.stable[i] = raw[i];
      end
    end
    // Monitor off drops every threshold sense
    next_st.stable[NUM_THRESH-1:0] = clear_when_off(st.mode, sense_view(next_st.stable));
    // Flags: rising crossing sets, write one clears, set wins
    for (int i = 0; i < NUM_THRESH; i++) begin
      crossed[i] = rising(next_st.stable[i], st.stable[i]);
      next_st.flag[i] = sticky_flag(crossed[i], irq_flag_clear_i[i], st.flag[i]);
    end
    // Shutdown latch held until cooled past hysteresis comparator
    next_st.shutdown = sticky_flag(st.stable[TRIP_BIT], st.sync2[RELEASE_BIT], st.shutdown);
    next_st.irq = irq_request(next_st.flag, thermal_thresh_mask_i);
  end

  assign sensing = is_sensing(st.mode);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Sense holds via comparator hysteresis (5 C falling)
  assign sensor_power_o = sensing;
  assign thermal_thresh_irq_flag_o = st.flag;
  assign thermal_thresh_sense_o = sense_view(st.stable);
  assign thermal_irq_o = st.irq;
  assign thermal_shutdown_o = st.shutdown;

endmodule // tmc_thermal_monitor_control

// ---- tmc_sensor_model.sv ----
// Comparator model for the on-die thermal sensor
`timescale 1ns/1ps
module tmc_sensor_model(
  input wire logic power_i,
  input wire logic [7:0] temp_i,
  output logic [5:0] comp_o,
  output logic trip_o,
  output logic release_o
);
  logic [5:0] s = 6'h00;
  // Sets at the threshold, releases 5 C below it
  always @(temp_i) for (int k = 0; k < 6; k++) if (temp_i >= 8'h50 + 8'h0F * k) s[k] = 1'b1;
    else if (temp_i < 8'h4B + 8'h0F * k) s[k] = 1'b0;
  // Unpowered threshold comparators show the inverse of the last value
  assign comp_o = power_i ? s : ~s;
  assign trip_o = temp_i >= 8'hA5;
  assign release_o = temp_i <= 8'h96;
endmodule // tmc_sensor_model

// ---- tmc_chk.sv ----
// Port checker for thermal monitor control
`timescale 1ns/1ps
module tmc_chk #(parameter int NUM_THRESH = 6) (input wire logic ref_clk_i, sys_rst_i, temp_monitor_enable_i,
  monitor_always_on_i, run_state_i, shutdown_trip_level_i, shutdown_release_i, sensor_power_o, thermal_irq_o,
  thermal_shutdown_o, input wire logic [NUM_THRESH-1:0] thresh_comp_i, irq_flag_clear_i, thermal_thresh_mask_i,
  thermal_thresh_irq_flag_o, thermal_thresh_sense_o);
  wire logic [NUM_THRESH-1:0] f = thermal_thresh_irq_flag_o, s = thermal_thresh_sense_o, m = thermal_thresh_mask_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_off; !temp_monitor_enable_i[*3]; endsequence
  property p_off; s_off |-> !sensor_power_o && s == 0; endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_aon; (temp_monitor_enable_i && run_state_i && monitor_always_on_i)[*2] |-> sensor_power_o; endproperty
  a_aon: assert property (p_aon) else $error("not always on");
  property p_hold; ($past(f & ~irq_flag_clear_i) & ~f) == 0; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_set; (f & ~$past(f) & ~(s & ~$past(s))) == 0; endproperty
  a_set: assert property (p_set) else $error("flag without rise");
  property p_irq; $stable(m) |-> thermal_irq_o == |(f & ~m); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_trip; $rose(thermal_shutdown_o) |-> $past(shutdown_trip_level_i, 3); endproperty
  a_trip: assert property (p_trip) else $error("shutdown without trip");
  property p_latch; !shutdown_release_i[*3] ##0 thermal_shutdown_o |=> thermal_shutdown_o; endproperty
  a_latch: assert property (p_latch) else $error("shutdown dropped");
  property p_db; $rose(s[0]) |-> $past(thresh_comp_i[0], 3); endproperty
  a_db: assert property (p_db) else $error("sense not debounced");
endmodule // tmc_chk
bind tmc_thermal_monitor_control tmc_chk #(.NUM_THRESH(NUM_THRESH)) u_chk(.*);

// ---- thermal_monitor_control_tb_top.sv ----
// Testbench for thermal monitor control
`timescale 1ns/1ps
module thermal_monitor_control_tb_top;
  logic c = 0, r = 1, en = 0, ao = 0, run = 0, sb = 0, tr, rl, pw, iq, sd;
  logic [5:0] cl = 6'h00, mk = 6'h00, cm, fl, se, n;
  logic [7:0] t = 8'h00;
  int err_count = 0, samples_checked = 0;
  initial forever #20 c = ~c;
  tmc_thermal_monitor_control #(.DEBOUNCE_CYC(4), .WINDOW_CYC(10), .PERIOD_CYC(40)) dut(.ref_clk_i(c), .sys_rst_i(r),
    .temp_monitor_enable_i(en), .monitor_always_on_i(ao), .run_state_i(run), .standby_state_i(sb), .thresh_comp_i(cm),
    .shutdown_trip_level_i(tr), .shutdown_release_i(rl), .irq_flag_clear_i(cl), .thermal_thresh_mask_i(mk),
    .sensor_power_o(pw), .thermal_thresh_irq_flag_o(fl), .thermal_thresh_sense_o(se), .thermal_irq_o(iq),
    .thermal_shutdown_o(sd));
  tmc_sensor_model pm(.power_i(pw), .temp_i(t), .comp_o(cm), .trip_o(tr), .release_o(rl));
  task tk(int k); repeat (k) @(posedge c); #2; endtask
  task ck(logic [5:0] g, e); samples_checked++;
    if (g !== e) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end endtask
  task final_report; $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed"); else $display("Testbench failed");
    $finish; endtask
  task ht(logic [7:0] v, logic [5:0] e); t = v; for (int i = 0; i < 40 && se !== e; i++) tk(1);
    ck(se, e); if (se !== e) final_report; endtask
  task dy(logic [5:0] e); tk(9); n = 6'h00; repeat (40) begin n = n + {5'h00, pw}; tk(1); end ck(n, e); endtask
  initial begin #100000; err_count++; final_report; end
  initial begin
    tk(5); r = 0; en = 1; run = 1; ao = 1; dy(6'h28);
    ht(8'h64, 6'h03); ck(fl, 6'h03); ck({5'h00, iq}, 6'h01); $display("crossing done");
    cl = 6'h3F; tk(1); cl = 6'h00; tk(1); ck(fl, 6'h00); ht(8'h59, 6'h01); ck(fl, 6'h00);
    $display("clear done");
    mk = 6'h3F; ht(8'hAA, 6'h3F); tk(9); ck(fl, 6'h3E); ck({4'h0, iq, sd}, 6'h01);
    ht(8'h9B, 6'h3F); tk(9); ck({4'h0, iq, sd}, 6'h01); mk = 6'h00; tk(2); ck({4'h0, iq, sd}, 6'h03);
    ht(8'h8C, 6'h1F); tk(9); ck({4'h0, iq, sd}, 6'h02); $display("shutdown done");
    ao = 0; dy(6'h0A); run = 0; sb = 1; ao = 1; dy(6'h0A);
    en = 0; dy(6'h00); ck(se, 6'h00); $display("modes done");
    final_report;
  end
endmodule // thermal_monitor_control_tb_top
